// file: design/rstm_defines.vh
// Constants of the reset manager with watchdog
`ifndef RSTM_DEFINES_VH
`define RSTM_DEFINES_VH

// ============================================================
// Register byte addresses on the AXI4-Lite bus
`define RSTM_ADDR_CTRL      32'h0000_0000
`define RSTM_ADDR_STATUS    32'h0000_0004
`define RSTM_ADDR_WDOG      32'h0000_0008

// ============================================================
// Bit positions of reset_control
`define RSTM_CTRL_UNLOCK    7
`define RSTM_CTRL_PCFG      6
`define RSTM_CTRL_BADACC    5
`define RSTM_CTRL_WDEN      4

// ============================================================
// Bit positions of reset_cause_status
`define RSTM_ST_SLEEP_REQ   7
`define RSTM_ST_WAS_SLEEP   6
`define RSTM_ST_BADACC      5
`define RSTM_ST_WDOG        4
`define RSTM_ST_PORT        3
`define RSTM_ST_LO          3
`define RSTM_ST_HI          6

// ============================================================
// Reset values
`define RSTM_CTRL_RST       4'h0
`define RSTM_FLAG_RST       1'b0
`define RSTM_WD_RST         4'h0

// ============================================================
// Watchdog
`define RSTM_KEY_FIRST      8'h0a
`define RSTM_KEY_SECOND     8'h03
`define RSTM_WD_LIMIT       4'h8
`define RSTM_WD_ONE         4'h1

// ============================================================
// Timing: tick period of the watchdog and clock rate
`define RSTM_WDT_TICK_MS    250
`define RSTM_CLK_KHZ        25000
`define RSTM_TICK_W         23

// ============================================================
// AXI responses
`define RSTM_RESP_OKAY      2'b00
`define RSTM_RESP_SLVERR    2'b10

`endif

// file: design/rstm_reset_manager.v
// Reset manager: reset sources, four internal resets, sleep control, watchdog, AXI4-Lite regs
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "rstm_defines.vh"

// Behaviour
// - Control bit 7 unlocks sleep entry
// - Control bit 6 adds port-config reset
// - Control bit 5 enables bad-access reset
// - Control bit 4 watchdog enable, sticky
// - Status bit 7 sleep request, reads 0
// - Status bit 6 was-sleeping, read-clear
// - Status bit 5 bad-access cause, read-clear
// - Status bit 4 watchdog cause, read-clear
// - Status bit 3 port-combination cause, read-clear
// - Watchdog register: key write, counter read
// - Six reset sources accepted
// - Sleep request is software reset source
// - Cold reset only on power-on or pin
// - Global reset from cold, port combination or enabled sources
// - Sleep reset in sleep or cold
// - Port-config reset gated for soft sources
// - Power-on held until regulator ready
// - Low external pin activates reset
// - Watchdog reset only when enabled, expired
// - Enabled bad access generates reset
// - Unlock then request enters sleep
// - Keys 0x0a then 0x03 clear watchdog
// - Counter 0..7, reset at eight
module rstm_reset_manager #(
    parameter TICK_CYCLES = `RSTM_WDT_TICK_MS * `RSTM_CLK_KHZ
) (
    input  wire        clock,
    input  wire        resetn,
    input  wire        supply_rise,
    input  wire        regulator_ready,
    input  wire        ext_reset_n,
    input  wire        port_combination,
    input  wire        bad_address_access,
    input  wire [31:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        cold_reset_n,
    output wire        global_reset_n,
    output wire        sleep_reset_n,
    output wire        port_cfg_reset_n,
    output wire        sleep_active
);

    // ============================================================
    // State
    reg                    por_reg;
    reg [`RSTM_CTRL_UNLOCK:`RSTM_CTRL_WDEN] ctrl_reg;
    reg                    sleep_mode_reg;
    reg [`RSTM_ST_HI:`RSTM_ST_LO] flag_reg;
    reg [3:0]              wd_count_reg;
    reg                    key_armed_reg;
    reg [`RSTM_TICK_W-1:0] tick_cnt_reg;
    reg                    tick_reg;

    reg                    cold_n_reg;
    reg                    global_n_reg;
    reg                    sleep_n_reg;
    reg                    pcfg_n_reg;

    reg                    awready_reg;
    reg                    wready_reg;
    reg [31:0]             awaddr_reg;
    reg [31:0]             wdata_reg;
    reg [3:0]              wstrb_reg;
    reg                    bvalid_reg;
    reg [1:0]              bresp_reg;
    reg                    arready_reg;
    reg                    rvalid_reg;
    reg [31:0]             rdata_reg;
    reg [1:0]              rresp_reg;

    localparam integer            TICK_LAST_I = TICK_CYCLES - 1;
    localparam [`RSTM_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`RSTM_TICK_W-1:0];

    // ============================================================
    // Reset source combination
    wire cold_now;
    wire wd_expired;
    wire wd_src;
    wire bad_src;
    wire soft_src;
    wire global_now;

    assign cold_now   = por_reg | ~ext_reset_n;
    assign wd_expired = (wd_count_reg == `RSTM_WD_LIMIT);
    assign wd_src     = ctrl_reg[`RSTM_CTRL_WDEN] & wd_expired;
    assign bad_src    = ctrl_reg[`RSTM_CTRL_BADACC] & bad_address_access;
    assign soft_src   = port_combination | wd_src | bad_src;
    assign global_now = cold_now | soft_src;

    // ============================================================
    // Register bus decode
    wire wr_fire;
    wire rd_fire;
    wire wr_ctrl;
    wire wr_status;
    wire wr_wdog;
    wire wr_hit;
    wire rd_status;
    wire rd_hit;
    wire [7:0] wr_byte;

    assign wr_fire   = ~awready_reg & ~wready_reg & ~bvalid_reg;
    assign rd_fire   = s_axi_arvalid & arready_reg;
    assign wr_byte   = wdata_reg[7:0];
    assign wr_ctrl   = wr_fire & wstrb_reg[0] & (awaddr_reg == `RSTM_ADDR_CTRL);
    assign wr_status = wr_fire & wstrb_reg[0] & (awaddr_reg == `RSTM_ADDR_STATUS);
    assign wr_wdog   = wr_fire & wstrb_reg[0] & (awaddr_reg == `RSTM_ADDR_WDOG);
    assign wr_hit    = (awaddr_reg == `RSTM_ADDR_CTRL) | (awaddr_reg == `RSTM_ADDR_STATUS)
                     | (awaddr_reg == `RSTM_ADDR_WDOG);
    assign rd_status = rd_fire & (s_axi_araddr == `RSTM_ADDR_STATUS);
    assign rd_hit    = (s_axi_araddr == `RSTM_ADDR_CTRL) | (s_axi_araddr == `RSTM_ADDR_STATUS)
                     | (s_axi_araddr == `RSTM_ADDR_WDOG);

    // ============================================================
    // Power-on reset: held from supply rise until regulator is up
    always @(posedge clock) begin
        if (!resetn) begin
            por_reg <= 1'b1;
        end else if (supply_rise) begin
            por_reg <= 1'b1;
        end else if (regulator_ready) begin
            por_reg <= 1'b0;
        end
    end

    // ============================================================
    // Control register, cleared only by cold reset
    always @(posedge clock) begin
        if (!resetn || cold_now) begin
            ctrl_reg <= `RSTM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg[`RSTM_CTRL_UNLOCK] <= wr_byte[`RSTM_CTRL_UNLOCK];
            ctrl_reg[`RSTM_CTRL_PCFG]   <= wr_byte[`RSTM_CTRL_PCFG];
            ctrl_reg[`RSTM_CTRL_BADACC] <= wr_byte[`RSTM_CTRL_BADACC];
            // Once set the enable stays set until cold reset
            ctrl_reg[`RSTM_CTRL_WDEN]   <= ctrl_reg[`RSTM_CTRL_WDEN]
                                         | wr_byte[`RSTM_CTRL_WDEN];
        end
    end

    // ============================================================
    // Sleep mode: entered by unlocked request, left by cold or port wake
    always @(posedge clock) begin
        if (!resetn || cold_now) begin
            sleep_mode_reg <= 1'b0;
        end else if (port_combination) begin
            sleep_mode_reg <= 1'b0;
        end else if (wr_status && wr_byte[`RSTM_ST_SLEEP_REQ]
                     && ctrl_reg[`RSTM_CTRL_UNLOCK] && !global_now) begin
            sleep_mode_reg <= 1'b1;
        end
    end

    // ============================================================
    // Sticky cause flags: hardware set wins over read-clear
    wire [`RSTM_ST_HI:`RSTM_ST_LO] flag_set;

    assign flag_set[`RSTM_ST_WAS_SLEEP] = sleep_mode_reg & port_combination;
    assign flag_set[`RSTM_ST_BADACC]    = bad_src;
    assign flag_set[`RSTM_ST_WDOG]      = wd_src;
    assign flag_set[`RSTM_ST_PORT]      = port_combination;

    genvar fi;
    generate
        for (fi = `RSTM_ST_LO; fi <= `RSTM_ST_HI; fi = fi + 1) begin : g_flag
            always @(posedge clock) begin
                if (!resetn || cold_now) begin
                    flag_reg[fi] <= `RSTM_FLAG_RST;
                end else if (flag_set[fi]) begin
                    flag_reg[fi] <= 1'b1;
                end else if (rd_status) begin
                    flag_reg[fi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // Watchdog tick divider, frozen in sleep
    always @(posedge clock) begin
        if (!resetn || global_now) begin
            tick_cnt_reg <= {`RSTM_TICK_W{1'b0}};
            tick_reg     <= 1'b0;
        end else if (sleep_mode_reg) begin
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= {`RSTM_TICK_W{1'b0}};
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    // ============================================================
    // Watchdog key sequence and counter
    wire key_clear;

    assign key_clear = wr_wdog & key_armed_reg & (wr_byte == `RSTM_KEY_SECOND);

    always @(posedge clock) begin
        if (!resetn || global_now) begin
            key_armed_reg <= 1'b0;
        end else if (wr_wdog) begin
            // Any write other than the first key cancels the sequence
            key_armed_reg <= (wr_byte == `RSTM_KEY_FIRST);
        end
    end

    always @(posedge clock) begin
        if (!resetn || global_now) begin
            wd_count_reg <= `RSTM_WD_RST;
        end else if (key_clear) begin
            wd_count_reg <= `RSTM_WD_RST;
        end else if (tick_reg && ctrl_reg[`RSTM_CTRL_WDEN] && !wd_expired) begin
            wd_count_reg <= wd_count_reg + `RSTM_WD_ONE;
        end
    end

    // ============================================================
    // Internal reset outputs
    always @(posedge clock) begin
        if (!resetn) begin
            cold_n_reg   <= 1'b0;
            global_n_reg <= 1'b0;
            sleep_n_reg  <= 1'b0;
            pcfg_n_reg   <= 1'b0;
        end else begin
            cold_n_reg   <= ~cold_now;
            global_n_reg <= ~global_now;
            sleep_n_reg  <= ~(cold_now | sleep_mode_reg);
            pcfg_n_reg   <= ~(cold_now
                              | (soft_src & ctrl_reg[`RSTM_CTRL_PCFG]));
        end
    end

    // ============================================================
    // AXI4-Lite write channel
    always @(posedge clock) begin
        if (!resetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `RSTM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awaddr_reg  <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg) begin
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? `RSTM_RESP_OKAY : `RSTM_RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // ============================================================
    // AXI4-Lite read channel
    reg [7:0] rd_byte;

    always @* begin
        rd_byte = 8'h00;
        case (s_axi_araddr)
            `RSTM_ADDR_CTRL: begin
                rd_byte = {ctrl_reg, 4'h0};
            end
            `RSTM_ADDR_STATUS: begin
                rd_byte = {1'b0, flag_reg, 3'h0};
            end
            `RSTM_ADDR_WDOG: begin
                rd_byte = {4'h0, wd_count_reg};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!resetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `RSTM_RESP_OKAY;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h00_0000, rd_byte};
            rresp_reg   <= rd_hit ? `RSTM_RESP_OKAY : `RSTM_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // ============================================================
    // Outputs
    assign s_axi_awready    = awready_reg;
    assign s_axi_wready     = wready_reg;
    assign s_axi_bresp      = bresp_reg;
    assign s_axi_bvalid     = bvalid_reg;
    assign s_axi_arready    = arready_reg;
    assign s_axi_rdata      = rdata_reg;
    assign s_axi_rresp      = rresp_reg;
    assign s_axi_rvalid     = rvalid_reg;
    assign cold_reset_n     = cold_n_reg;
    assign global_reset_n   = global_n_reg;
    assign sleep_reset_n    = sleep_n_reg;
    assign port_cfg_reset_n = pcfg_n_reg;
    assign sleep_active     = sleep_mode_reg;

endmodule

// file: verif/rstm_reset_manager_properties.sv
// Checker of the reset manager output relations
`timescale 1ns/10ps
`include "rstm_defines.vh"
module rstm_reset_manager_chk (
    input wire        clock,
    input wire        resetn,
    input wire        supply_rise,
    input wire        ext_reset_n,
    input wire        port_combination,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        cold_reset_n,
    input wire        global_reset_n,
    input wire        sleep_reset_n,
    input wire        port_cfg_reset_n,
    input wire        sleep_active
);
    // ============================================================
    // Reset relations
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_cold_pin: assert property (!ext_reset_n |=> !cold_reset_n)
        else $error("cold reset not raised by pin");
    a_cold_cause: assert property ($fell(cold_reset_n) |-> !$past(ext_reset_n)
        || $past(supply_rise) || $past(supply_rise, 2))
        else $error("cold reset without cause");
    a_cold_all: assert property (!cold_reset_n |-> !global_reset_n && !sleep_reset_n
        && !port_cfg_reset_n)
        else $error("cold reset not spread");
    a_pcfg_gated: assert property (!port_cfg_reset_n |-> !global_reset_n)
        else $error("port reset outside global reset");
    a_port_global: assert property (port_combination |=> !global_reset_n)
        else $error("port combination gave no global reset");
    a_sleep_hold: assert property (sleep_active ##1 sleep_active |-> !sleep_reset_n)
        else $error("sleep reset released in sleep");
    a_sleep_only: assert property (!sleep_reset_n |-> !cold_reset_n || sleep_active
        || $past(sleep_active))
        else $error("sleep reset without sleep or cold");
    // ============================================================
    // Fixed read fields
    a_ctrl_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `RSTM_ADDR_CTRL |=> s_axi_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    a_status_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `RSTM_ADDR_STATUS |=> !s_axi_rdata[7] && s_axi_rdata[2:0] == 3'h0)
        else $error("status fixed bits not zero");
    a_wdog_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `RSTM_ADDR_WDOG |=> s_axi_rdata[7:4] == 4'h0)
        else $error("watchdog high bits not zero");
endmodule

// file: verif/rstm_sys_model.sv
// Model of the system blocks that receive the four resets
`timescale 1ns/10ps
module rstm_sys_model (
    input  wire       clock,
    input  wire       clear,
    input  wire       cold_reset_n,
    input  wire       global_reset_n,
    input  wire       sleep_reset_n,
    input  wire       port_cfg_reset_n,
    output reg  [3:0] hit
);
    // Each block notes which resets reached it since the last clear
    always @(posedge clock) begin
        if (clear) begin
            hit <= 4'h0;
        end else begin
            hit <= hit | ~{cold_reset_n, global_reset_n, sleep_reset_n, port_cfg_reset_n};
        end
    end
endmodule

// file: verif/tb_rstm_reset_manager.sv
// Self-checking testbench of the reset manager
`timescale 1ns/10ps
`include "rstm_defines.vh"
module tb_rstm_reset_manager;
    reg         clock = 1'b0;
    reg         resetn = 1'b0;
    reg         supply_rise = 1'b0;
    reg         regulator_ready = 1'b0;
    reg         ext_reset_n = 1'b1;
    reg         port_comb = 1'b0;
    reg         bad_acc = 1'b0;
    reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, ua;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg         clear = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire        cold_n, global_n, sleep_n, pcfg_n, sleep_active;
    wire [3:0]  hit;
    reg  [65:0] notes[$];
    reg  [65:0] e;
    reg  [1:0]  last_bresp;
    integer     n_fail = 0, check_count = 0, i;

    rstm_reset_manager #(.TICK_CYCLES(4)) dut (
        .clock(clock), .resetn(resetn), .supply_rise(supply_rise),
        .regulator_ready(regulator_ready), .ext_reset_n(ext_reset_n),
        .port_combination(port_comb), .bad_address_access(bad_acc),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cold_reset_n(cold_n), .global_reset_n(global_n),
        .sleep_reset_n(sleep_n), .port_cfg_reset_n(pcfg_n), .sleep_active(sleep_active));
    rstm_sys_model sys (.clock(clock), .clear(clear), .cold_reset_n(cold_n),
        .global_reset_n(global_n), .sleep_reset_n(sleep_n), .port_cfg_reset_n(pcfg_n),
        .hit(hit));

    always #20 clock = ~clock;

    task chk(input string nm, input [33:0] ex, input [33:0] got);
        begin
            check_count = check_count + 1;
            if (got !== ex) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d failures %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    task wr(input [31:0] a, input [7:0] d);
        reg ta, tw;
        begin
            ta = 1'b0;
            tw = 1'b0;
            @(posedge clock);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(ta && tw)) begin
                @(posedge clock);
                if (!ta && awready) begin
                    awvalid <= 1'b0;
                    ta = 1'b1;
                end
                if (!tw && wready) begin
                    wvalid <= 1'b0;
                    tw = 1'b1;
                end
            end
            do @(posedge clock); while (!bvalid);
            last_bresp = bresp;
            bready <= 1'b0;
        end
    endtask

    task rd(input [31:0] a, input [31:0] ex, input [1:0] rs, input [31:0] m);
        begin
            notes.push_back({m, rs, ex});
            @(posedge clock);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge clock); while (!arready);
            arvalid <= 1'b0;
            do @(posedge clock); while (!rvalid);
            rready <= 1'b0;
        end
    endtask

    // Pulse one source for a cycle: 0 bad access, 1 port combination, 2 pin
    task src(input integer w, input [3:0] ex);
        begin
            @(posedge clock);
            clear <= 1'b1;
            @(posedge clock);
            clear <= 1'b0;
            bad_acc <= (w == 0);
            port_comb <= (w == 1);
            ext_reset_n <= (w != 2);
            @(posedge clock);
            bad_acc <= 1'b0;
            port_comb <= 1'b0;
            ext_reset_n <= 1'b1;
            repeat (5) @(posedge clock);
            chk("reset hits", ex, hit);
        end
    endtask

    always @(posedge clock) begin
        if (rvalid && rready) begin
            e = notes.pop_front();
            chk("read", e[33:0], {rresp, rdata} & {2'b11, e[65:34]});
        end
    end

    initial begin
        #(40 * 20000);
        n_fail = n_fail + 1;
        stop_test;
    end

    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(49049));
        ua = 32'h0c + (($urandom % 8) << 2);
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        chk("cold held", 1'b0, cold_n);
        regulator_ready <= 1'b1;
        repeat (3) @(posedge clock);
        chk("cold release", 1'b1, cold_n);
        rd(`RSTM_ADDR_CTRL, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        rd(`RSTM_ADDR_STATUS, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        rd(`RSTM_ADDR_WDOG, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        rd(ua, 32'h0, `RSTM_RESP_SLVERR, 32'hffffffff);
        wr(ua, 8'hff);
        chk("bresp", `RSTM_RESP_SLVERR, last_bresp);
        src(0, 4'h0);
        wr(`RSTM_ADDR_CTRL, {4'h6, 4'($urandom)});
        rd(`RSTM_ADDR_CTRL, 32'h60, `RSTM_RESP_OKAY, 32'hffffffff);
        src(0, 4'b0101);
        rd(`RSTM_ADDR_STATUS, 32'h20, `RSTM_RESP_OKAY, 32'hffffffff);
        rd(`RSTM_ADDR_STATUS, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        wr(`RSTM_ADDR_CTRL, 8'h20);
        src(1, 4'b0100);
        rd(`RSTM_ADDR_STATUS, 32'h08, `RSTM_RESP_OKAY, 32'hffffffff);
        wr(`RSTM_ADDR_STATUS, 8'h80);
        repeat (2) @(posedge clock);
        chk("locked sleep", 1'b0, sleep_active);
        wr(`RSTM_ADDR_CTRL, 8'h80);
        wr(`RSTM_ADDR_STATUS, 8'h80);
        repeat (3) @(posedge clock);
        chk("sleep", 3'b101, {sleep_active, sleep_n, global_n});
        src(1, 4'b0110);
        chk("woken", 1'b0, sleep_active);
        rd(`RSTM_ADDR_STATUS, 32'h48, `RSTM_RESP_OKAY, 32'hffffffff);
        wr(`RSTM_ADDR_CTRL, 8'h10);
        wr(`RSTM_ADDR_CTRL, 8'h00);
        rd(`RSTM_ADDR_CTRL, 32'h10, `RSTM_RESP_OKAY, 32'hffffffff);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            wr(`RSTM_ADDR_WDOG, `RSTM_KEY_FIRST);
            wr(`RSTM_ADDR_WDOG, `RSTM_KEY_SECOND);
            rd(`RSTM_ADDR_WDOG, 32'h0, `RSTM_RESP_OKAY, 32'hfffffff8);
        end
        chk("fed watchdog", 1'b0, hit[2]);
        wr(`RSTM_ADDR_WDOG, `RSTM_KEY_FIRST);
        wr(`RSTM_ADDR_WDOG, 8'h05);
        wr(`RSTM_ADDR_WDOG, `RSTM_KEY_SECOND);
        i = 0;
        while (global_n === 1'b1 && i < 40) begin
            @(posedge clock);
            i = i + 1;
        end
        chk("expiry time", 1'b1, i <= 24);
        rd(`RSTM_ADDR_STATUS, 32'h10, `RSTM_RESP_OKAY, 32'hffffffff);
        src(2, 4'b1111);
        rd(`RSTM_ADDR_CTRL, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        rd(`RSTM_ADDR_STATUS, 32'h0, `RSTM_RESP_OKAY, 32'hffffffff);
        regulator_ready <= 1'b0;
        supply_rise <= 1'b1;
        @(posedge clock);
        supply_rise <= 1'b0;
        repeat (6) @(posedge clock);
        chk("supply cold", 1'b0, cold_n);
        regulator_ready <= 1'b1;
        repeat (3) @(posedge clock);
        chk("supply release", 1'b1, cold_n);
        stop_test;
    end
endmodule

bind rstm_reset_manager rstm_reset_manager_chk u_chk (.clock(clock), .resetn(resetn),
    .supply_rise(supply_rise), .ext_reset_n(ext_reset_n), .port_combination(port_combination),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .cold_reset_n(cold_reset_n), .global_reset_n(global_reset_n),
    .sleep_reset_n(sleep_reset_n), .port_cfg_reset_n(port_cfg_reset_n),
    .sleep_active(sleep_active));
